// file: rtl/buf_ack_pkg.sv
// shared types and constants for the buffered acknowledge controller
// assumes a byte-level bus engine on the same clock feeds it event pulses
package buf_ack_pkg;

  localparam int unsigned count_width = 7;
  localparam logic [count_width-1:0] count_reset = 7'h00;
  localparam logic [count_width-1:0] count_step = 7'h01;
  localparam logic ack_level = 1'h1;
  localparam logic nack_level = 1'h0;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_master_addr = 3'b001,
    st_master_data = 3'b010,
    st_slave_data = 3'b011
  } seq_state_type;

  // software-set controls, held steady by the host during a sequence except ack_enable
  typedef struct packed {
    logic ack_enable;
    logic last_byte_nack_select;
    logic [count_width-1:0] buffer_byte_count;
  } cfg_type;

  // one-cycle pulses from the bus engine
  typedef struct packed {
    logic master_start;
    logic master_read;
    logic addr_sent;
    logic own_addr;
    logic slave_read;
    logic byte_done;
    logic stop_seen;
  } bus_event_type;

endpackage

// file: rtl/buf_ack_ctrl.sv
// buffered-mode sequence and acknowledge decisions for the bus controller
// assumes the byte engine on clk_in pulses events and drives acks from ack_out
// Contract
// - as master the block sends the address and then moves exactly buffer_byte_count data bytes.
// - with ack_enable low a received own slave address is answered with a not-acknowledge only while idle.
// - once addressed as a slave the block moves a sequence of buffer_byte_count bytes.
// - with last_byte_nack_select low the final received byte of a sequence is acknowledged.
// - with last_byte_nack_select high the final received byte of a sequence is not-acknowledged.
// - with ack_enable low an addressed slave drops to non-addressed after the last byte of a sequence.
// - in slave mode the final-byte not-acknowledge only happens if no stop ended the message earlier.
`timescale 1ns/10ps
`default_nettype none
module buf_ack_ctrl
  import buf_ack_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire cfg_type cfg_in,
  input wire bus_event_type event_in,
  output logic ack_valid_out,
  output logic ack_out,
  output logic addressed_out,
  output logic master_busy_out,
  output logic seq_done_out,
  output logic [count_width-1:0] byte_index_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  seq_state_type state_q, state_d;
  logic [count_width-1:0] count_q, count_d;
  logic read_q, read_d;
  logic ack_valid_q, ack_valid_d;
  logic ack_q, ack_d;
  logic done_q, done_d;
  logic [count_width-1:0] count_inc;
  logic last_byte;
  logic final_ack;

  assign count_inc = count_q + count_step;
  assign last_byte = (count_inc == cfg_in.buffer_byte_count);
  // final byte answer chosen by the select bit, earlier bytes always acked
  assign final_ack = cfg_in.last_byte_nack_select ? nack_level : ack_level;

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    read_d = read_q;
    ack_valid_d = 1'b0;
    ack_d = ack_q;
    done_d = 1'b0;
    case (state_q)
      st_idle: begin
        if (event_in.master_start) begin
          state_d = st_master_addr;
          count_d = count_reset;
          read_d = event_in.master_read;
        end else if (event_in.own_addr) begin
          ack_valid_d = 1'b1;
          if (cfg_in.ack_enable) begin
            ack_d = ack_level;
            state_d = st_slave_data;
            count_d = count_reset;
            // master reads means the slave transmits
            read_d = ~event_in.slave_read;
          end else begin
            ack_d = nack_level;
          end
        end
      end
      st_master_addr: begin
        if (event_in.stop_seen) begin
          state_d = st_idle;
        end else if (event_in.addr_sent) begin
          // a zero count ends right after the address
          if (cfg_in.buffer_byte_count == count_reset) begin
            state_d = st_idle;
            done_d = 1'b1;
          end else begin
            state_d = st_master_data;
          end
        end
      end
      st_master_data: begin
        if (event_in.stop_seen) begin
          state_d = st_idle;
        end else if (event_in.byte_done) begin
          count_d = count_inc;
          if (read_q) begin
            ack_valid_d = 1'b1;
            ack_d = last_byte ? final_ack : ack_level;
          end
          if (last_byte) begin
            state_d = st_idle;
            done_d = 1'b1;
          end
        end
      end
      st_slave_data: begin
        // a stop before the final byte ends the message, so no final nack
        if (event_in.stop_seen) begin
          state_d = st_idle;
        end else if (event_in.byte_done) begin
          count_d = count_inc;
          if (read_q) begin
            ack_valid_d = 1'b1;
            ack_d = last_byte ? final_ack : ack_level;
          end
          if (last_byte) begin
            done_d = 1'b1;
            count_d = count_reset;
            if (!cfg_in.ack_enable) begin
              state_d = st_idle;
            end
          end
        end
      end
      default: begin
        state_d = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= st_idle;
      count_q <= count_reset;
      read_q <= 1'b0;
      ack_valid_q <= 1'b0;
      ack_q <= nack_level;
      done_q <= 1'b0;
    end else if (enable_in) begin
      state_q <= state_d;
      count_q <= count_d;
      read_q <= read_d;
      ack_valid_q <= ack_valid_d;
      ack_q <= ack_d;
      done_q <= done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops

  logic addressed_q, busy_q;
  logic [count_width-1:0] index_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      addressed_q <= 1'b0;
      busy_q <= 1'b0;
      index_q <= count_reset;
    end else if (enable_in) begin
      addressed_q <= (state_d == st_slave_data);
      busy_q <= (state_d == st_master_addr) || (state_d == st_master_data);
      index_q <= count_d;
    end
  end

  assign ack_valid_out = ack_valid_q;
  assign ack_out = ack_q;
  assign addressed_out = addressed_q;
  assign master_busy_out = busy_q;
  assign seq_done_out = done_q;
  assign byte_index_out = index_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_own_addr_nack: assert property (@(posedge clk_in) disable iff (reset_in)
    (enable_in && state_q == st_idle && !event_in.master_start && event_in.own_addr && !cfg_in.ack_enable)
    |=> (ack_valid_out && ack_out == nack_level && !addressed_out))
    else $error("own address not refused while ack disabled");

  chk_master_count_done: assert property (@(posedge clk_in) disable iff (reset_in)
    (enable_in && state_q == st_master_data && !event_in.stop_seen && event_in.byte_done && last_byte)
    |=> (seq_done_out && !master_busy_out && byte_index_out == cfg_in.buffer_byte_count))
    else $error("master sequence did not end at byte count");

  chk_master_no_early: assert property (@(posedge clk_in) disable iff (reset_in)
    (enable_in && state_q == st_master_data && !event_in.stop_seen && event_in.byte_done && !last_byte)
    |=> (master_busy_out && !seq_done_out))
    else $error("master sequence ended before byte count");

  chk_slave_count: assert property (@(posedge clk_in) disable iff (reset_in)
    (enable_in && state_q == st_slave_data && !event_in.stop_seen && event_in.byte_done)
    |=> (seq_done_out == $past(last_byte)))
    else $error("slave sequence length wrong");

  chk_final_ack_lb0: assert property (@(posedge clk_in) disable iff (reset_in)
    (enable_in && (state_q == st_master_data || state_q == st_slave_data) && read_q && !event_in.stop_seen
     && event_in.byte_done && last_byte && !cfg_in.last_byte_nack_select)
    |=> (ack_valid_out && ack_out == ack_level))
    else $error("final byte not acked with select low");

  chk_final_nack_lb1: assert property (@(posedge clk_in) disable iff (reset_in)
    (enable_in && (state_q == st_master_data || state_q == st_slave_data) && read_q && !event_in.stop_seen
     && event_in.byte_done && last_byte && cfg_in.last_byte_nack_select)
    |=> (ack_valid_out && ack_out == nack_level))
    else $error("final byte not refused with select high");

  chk_mid_byte_ack: assert property (@(posedge clk_in) disable iff (reset_in)
    (enable_in && (state_q == st_master_data || state_q == st_slave_data) && read_q && !event_in.stop_seen
     && event_in.byte_done && !last_byte)
    |=> (ack_valid_out && ack_out == ack_level))
    else $error("middle byte not acked");

  chk_slave_release: assert property (@(posedge clk_in) disable iff (reset_in)
    (enable_in && state_q == st_slave_data && !event_in.stop_seen && event_in.byte_done && last_byte
     && !cfg_in.ack_enable)
    |=> (!addressed_out && seq_done_out))
    else $error("slave stayed addressed after last byte");

  chk_stop_no_nack: assert property (@(posedge clk_in) disable iff (reset_in)
    (enable_in && state_q == st_slave_data && event_in.stop_seen)
    |=> (!ack_valid_out && !addressed_out && !seq_done_out))
    else $error("stop did not end the slave message cleanly");

endmodule
`default_nettype wire

// file: verif/bus_side_model.sv
// far-side bus engine model: pulses one transfer's events
// assumes the controller shares clk_in; gaps between events are random
`timescale 1ns/10ps
`default_nettype none
module bus_side_model
  import buf_ack_pkg::*;
(
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [1:0] kind_in,
  input wire logic [7:0] len_in,
  input wire logic [7:0] stop_in,
  output bus_event_type event_out,
  output logic busy_out
);
  initial begin
    event_out = '0;
    busy_out = 1'b0;
  end
  // a gap lowers the pulse first, so no two writes share a time step
  task automatic emit(input logic [6:0] ev);
    event_out = bus_event_type'(ev);
    @(posedge clk_in) #1;
    if ($urandom_range(0, 1) == 1) begin
      event_out = '0;
      @(posedge clk_in) #1;
    end
  endtask
  always begin
    @(posedge clk_in iff go_in) #1;
    busy_out = 1'b1;
    if (kind_in[1]) begin
      emit({4'h1, kind_in[0], 2'h0});
    end else begin
      emit({1'b1, kind_in[0], 5'h00});
      emit(7'h10);
    end
    for (int i = 0; i < len_in; i++) begin
      if (i == stop_in) begin
        emit(7'h01);
        break;
      end
      emit(7'h02);
    end
    event_out = '0;
    busy_out = 1'b0;
  end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// random and corner transfers against the buffered ack controller
// assumes bus_side_model stands in for the byte engine
`timescale 1ns/10ps
`default_nettype none
module testbench
  import buf_ack_pkg::*;
;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic run = 1'b1;
  logic go = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [7:0] len = 8'h00;
  logic [7:0] stop_at = 8'hff;
  cfg_type cfg = '0;
  bus_event_type ev;
  logic busy, ack_valid, ack, addressed, mbusy, done, last_ack;
  logic [count_width-1:0] idx;
  int mismatches = 0;
  int checked = 0;
  int acks = 0;
  int dones = 0;
  int cycles = 0;
  always #5 clk_in = ~clk_in;
  bus_side_model far (.clk_in(clk_in), .go_in(go), .kind_in(kind), .len_in(len), .stop_in(stop_at),
    .event_out(ev), .busy_out(busy));
  buf_ack_ctrl dut (.clk_in(clk_in), .reset_in(reset_in), .enable_in(run), .cfg_in(cfg), .event_in(ev),
    .ack_valid_out(ack_valid), .ack_out(ack), .addressed_out(addressed), .master_busy_out(mbusy),
    .seq_done_out(done), .byte_index_out(idx));
  ////////////////////////////////////////////////////////////////
  task wrap_up();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // outputs settle well before the falling edge
  always @(negedge clk_in) begin
    cycles++;
    if (ack_valid === 1'b1) begin
      acks++;
      last_ack = ack;
    end
    if (done === 1'b1) dones++;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end
  end
  function automatic logic [7:0] exp_acks(input logic [1:0] k, input logic ae, input logic [7:0] n, s);
    logic [7:0] m;
    m = (s < n) ? s : n;
    if (!k[1]) return k[0] ? m : 8'h00;
    if (!ae) return 8'h01;
    return k[0] ? 8'h01 : 8'h01 + m;
  endfunction
  // reset before each transfer leaves no state from the last one
  task automatic trial(input logic [1:0] k, input logic ae, drop, lb, input logic [7:0] n, s);
    logic rx, stp, exp_last;
    rx = k[1] ? !k[0] : k[0];
    stp = s < n;
    exp_last = (k[1] && !ae) ? 1'b0 : (rx && !stp && n != 0) ? !lb : 1'b1;
    reset_in = 1'b1;
    @(posedge clk_in) #1 reset_in = 1'b0;
    check({3'h0, mbusy, addressed, ack_valid, done, ack}, 8'h00);
    cfg = '{ack_enable: ae, last_byte_nack_select: lb, buffer_byte_count: n[6:0]};
    kind = k;
    len = n;
    stop_at = s;
    acks = 0;
    dones = 0;
    last_ack = 1'b1;
    go = 1'b1;
    @(posedge clk_in) #1 go = 1'b0;
    @(posedge clk_in) #1 if (drop) cfg.ack_enable = 1'b0;
    wait (!busy);
    repeat (3) @(posedge clk_in);
    #1;
    check(8'(acks), exp_acks(k, ae, n, s));
    check(8'(dones), ((k[1] && !ae) || stp) ? 8'h00 : 8'h01);
    check(8'(last_ack), 8'(exp_last));
    check(8'(addressed), 8'(k[1] && ae && !drop && !stp));
    check(8'(mbusy), 8'h00);
    check(8'(idx), (!k[1] || (ae && stp)) ? ((s < n) ? s : n) : 8'h00);
    $display("transfer kind %0d len %0d ended", k, n);
  endtask
  // clock enable held low for a whole transfer: every event must be lost
  task automatic frozen(input logic [1:0] k, input logic [7:0] n);
    reset_in = 1'b1;
    @(posedge clk_in) #1 reset_in = 1'b0;
    run = 1'b0;
    cfg = '{ack_enable: 1'b1, last_byte_nack_select: 1'b1, buffer_byte_count: n[6:0]};
    kind = k;
    len = n;
    stop_at = 8'hff;
    acks = 0;
    dones = 0;
    go = 1'b1;
    @(posedge clk_in) #1 go = 1'b0;
    @(posedge clk_in) #1;
    wait (!busy);
    repeat (3) @(posedge clk_in);
    #1;
    check(8'(acks + dones), 8'h00);
    check({6'h00, addressed, mbusy}, 8'h00);
    run = 1'b1;
    $display("frozen transfer kind %0d len %0d ended", k, n);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0] k;
    logic [7:0] n, s;
    void'($urandom(6));
    // the first trial adds the sixth reset edge and releases it
    repeat (5) @(posedge clk_in);
    trial(2'h1, 1'b1, 1'b0, 1'b1, 8'h01, 8'hff);
    trial(2'h2, 1'b1, 1'b1, 1'b1, 8'h03, 8'h02);
    trial(2'h2, 1'b1, 1'b1, 1'b0, 8'h02, 8'hff);
    trial(2'h3, 1'b0, 1'b0, 1'b0, 8'h02, 8'hff);
    trial(2'h0, 1'b0, 1'b0, 1'b1, 8'h00, 8'hff);
    frozen(2'h2, 8'h02);
    frozen(2'h1, 8'h02);
    for (int i = 0; i < 40; i++) begin
      k = 2'($urandom_range(0, 3));
      n = 8'(k[1] ? $urandom_range(1, 6) : $urandom_range(0, 6));
      s = ($urandom_range(0, 1) == 1) ? 8'($urandom_range(0, n)) : 8'hff;
      trial(k, 1'($urandom), 1'($urandom), 1'($urandom), n, s);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
